/* src/stream_offset_pkg.sv */
/*
 * constants for the per-stream input frame offset block: register indices,
 * field layout, reset values and the aligner state encoding.
 * assumes an apb slave with 32-bit data, one aligned word per register.
 */
package stream_offset_pkg;
    localparam int          num_streams     = 16;
    localparam int          streams_per_reg = 4;
    localparam int          num_offset_regs = 4;
    localparam int          field_w         = 4;
    localparam int          edge_pos        = 0;
    localparam int          offset_lsb      = 1;
    localparam int          offset_w        = 3;
    localparam int          reg_w           = 16;
    localparam int          addr_w          = 12;

    // register indices; byte address is four times the index
    localparam logic [9:0]  idx_offset_0_3   = 10'h003;
    localparam logic [9:0]  idx_offset_4_7   = 10'h004;
    localparam logic [9:0]  idx_offset_8_11  = 10'h005;
    localparam logic [9:0]  idx_offset_12_15 = 10'h006;
    localparam logic [9:0]  idx_mode         = 10'h007;
    localparam logic [9:0]  idx_status       = 10'h008;

    localparam logic [15:0] offset_reset     = 16'h0000;
    localparam logic [15:0] status_reset     = 16'h0000;
    localparam int          mode_gci_pos     = 0;
    localparam logic [3:0]  half_cnt_max     = 4'hf;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_wait = 2'b01,
        st_run  = 2'b10
    } align_state_e;
endpackage : stream_offset_pkg

/* src/stream_align_if.sv */
/*
 * per-stream carrier between the register side and one stream aligner.
 * assumes edge and frame strobes are one-cycle pulses in the pclk domain.
 */
`timescale 1ns/1ps
interface stream_align_if;
    logic       link_rise;
    logic       link_fall;
    logic       frame_ref;
    logic       gci_mode;
    logic       data_in;
    logic [2:0] offset;
    logic       latch_edge;
    logic       frame_start;
    logic       bit_valid;
    logic       bit_out;

    modport ctl (
        output link_rise, link_fall, frame_ref, gci_mode, data_in, offset, latch_edge,
        input  frame_start, bit_valid, bit_out
    );
    modport aligner (
        input  link_rise, link_fall, frame_ref, gci_mode, data_in, offset, latch_edge,
        output frame_start, bit_valid, bit_out
    );
endinterface : stream_align_if

/* src/stream_aligner.sv */
/*
 * one input stream aligner: counts half link-clock periods after the frame
 * reference and then samples the stream on the selected edge.
 * assumes link edges and frame reference arrive as pclk-domain pulses.
 */
`timescale 1ns/1ps
module stream_aligner (
    input  wire logic     pclk,
    input  wire logic     presetn,
    stream_align_if.aligner al
);
    typedef struct packed {
        stream_offset_pkg::align_state_e state;
        logic [3:0]                      half_cnt;
        logic                            bit_out;
        logic                            frame_start;
        logic                            bit_valid;
    } align_s;

    align_s     cur;
    align_s     next_cur;
    logic [3:0] target;
    logic       sample_edge;

    // whole periods doubled plus a half when the edge bit is set
    assign target = {al.offset, al.latch_edge};
    // native: 0 rising, 1 falling; gci: the reverse
    assign sample_edge = (al.latch_edge ^ al.gci_mode) ? al.link_fall
                                                        : al.link_rise;

    always_comb begin
        next_cur             = cur;
        next_cur.frame_start = 1'b0;
        next_cur.bit_valid   = 1'b0;
        if (al.frame_ref) begin
            next_cur.state    = stream_offset_pkg::st_wait;
            next_cur.half_cnt = '0;
        end else begin
            case (cur.state)
                stream_offset_pkg::st_wait: begin
                    if (sample_edge && cur.half_cnt >= target) begin
                        next_cur.bit_out     = al.data_in;
                        next_cur.frame_start = 1'b1;
                        next_cur.bit_valid   = 1'b1;
                        next_cur.state       = stream_offset_pkg::st_run;
                    end else if ((al.link_rise || al.link_fall)
                                 && cur.half_cnt != stream_offset_pkg::half_cnt_max) begin
                        next_cur.half_cnt = cur.half_cnt + 4'h1;
                    end
                end
                stream_offset_pkg::st_run: begin
                    if (sample_edge) begin
                        next_cur.bit_out   = al.data_in;
                        next_cur.bit_valid = 1'b1;
                    end
                end
                stream_offset_pkg::st_idle: begin
                    next_cur.state = stream_offset_pkg::st_idle;
                end
                default: begin
                    next_cur.state = stream_offset_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{state: stream_offset_pkg::st_idle, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign al.frame_start = cur.frame_start;
    assign al.bit_valid   = cur.bit_valid;
    assign al.bit_out     = cur.bit_out;
endmodule : stream_aligner

/* src/stream_input_frame_offset.sv */
/*
 * per-stream input frame offset block: apb register file holding the four
 * offset registers, a mode and a status register, link edge detection and
 * sixteen stream aligners.
 * assumes link clock, frame pulse and streams are synchronous to pclk and
 * the link clock runs at most at a quarter of pclk.
 */
`timescale 1ns/1ps
module stream_input_frame_offset (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk_in,
    input  wire logic        frame_pulse_in,
    input  wire logic [15:0] serial_stream_in,
    output logic      [15:0] rx_frame_start,
    output logic      [15:0] rx_bit_valid,
    output logic      [15:0] rx_bit
);
    typedef struct packed {
        logic                  prev_clk;
        logic                  prev_fp;
        logic [3:0][15:0]      offset_reg;
        logic                  gci_mode;
        logic [15:0]           status;
        logic [31:0]           prdata;
        logic                  pslverr;
    } top_s;

    top_s        cur;
    top_s        next_cur;
    logic [9:0]  idx;
    logic        link_rise;
    logic        link_fall;
    logic        frame_ref;
    logic        setup;
    logic        wr_access;
    logic        idx_is_offset;
    logic [1:0]  offset_sel;
    logic [15:0] frame_start_vec;
    logic [15:0] bit_valid_vec;
    logic [15:0] bit_vec;

    assign idx           = paddr[11:2];
    assign setup         = psel && !penable;
    assign wr_access     = psel && penable && pwrite;
    assign idx_is_offset = idx >= stream_offset_pkg::idx_offset_0_3
                        && idx <= stream_offset_pkg::idx_offset_12_15;
    assign offset_sel    = 2'(idx - stream_offset_pkg::idx_offset_0_3);
    assign link_rise     = link_clk_in && !cur.prev_clk;
    assign link_fall     = !link_clk_in && cur.prev_clk;
    // frame reference at the rising edge of the frame pulse
    assign frame_ref     = frame_pulse_in && !cur.prev_fp;

    always_comb begin
        next_cur          = cur;
        next_cur.prev_clk = link_clk_in;
        next_cur.prev_fp  = frame_pulse_in;

        // status: cleared by the new frame, a start in the same cycle wins
        if (frame_ref) begin
            next_cur.status = '0;
        end
        next_cur.status = next_cur.status | frame_start_vec;

        // read data and error captured in the setup cycle
        if (setup) begin
            next_cur.prdata  = '0;
            next_cur.pslverr = 1'b0;
            if (idx_is_offset) begin
                next_cur.prdata = {16'h0000, cur.offset_reg[offset_sel]};
            end else if (idx == stream_offset_pkg::idx_mode) begin
                next_cur.prdata[stream_offset_pkg::mode_gci_pos] = cur.gci_mode;
            end else if (idx == stream_offset_pkg::idx_status) begin
                next_cur.prdata = {16'h0000, cur.status};
            end else begin
                next_cur.pslverr = 1'b1;
            end
        end

        if (wr_access) begin
            if (idx_is_offset) begin
                next_cur.offset_reg[offset_sel] = pwdata[15:0];
            end else if (idx == stream_offset_pkg::idx_mode) begin
                next_cur.gci_mode = pwdata[stream_offset_pkg::mode_gci_pos];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{offset_reg: {4{stream_offset_pkg::offset_reset}},
                     status:     stream_offset_pkg::status_reset,
                     default:    '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign pready         = 1'b1;
    assign prdata         = cur.prdata;
    assign pslverr        = cur.pslverr;
    assign rx_frame_start = frame_start_vec;
    assign rx_bit_valid   = bit_valid_vec;
    assign rx_bit         = bit_vec;

    for (genvar n = 0; n < stream_offset_pkg::num_streams; n++) begin : g_stream
        localparam int reg_i = n / stream_offset_pkg::streams_per_reg;
        localparam int lsb   = (n % stream_offset_pkg::streams_per_reg)
                             * stream_offset_pkg::field_w;
        stream_align_if al ();

        assign al.link_rise  = link_rise;
        assign al.link_fall  = link_fall;
        assign al.frame_ref  = frame_ref;
        assign al.gci_mode   = cur.gci_mode;
        assign al.data_in    = serial_stream_in[n];
        // edge bit lowest, three offset bits above it
        assign al.latch_edge = cur.offset_reg[reg_i][lsb + stream_offset_pkg::edge_pos];
        assign al.offset     = cur.offset_reg[reg_i][lsb + stream_offset_pkg::offset_lsb
                                                     +: stream_offset_pkg::offset_w];
        assign frame_start_vec[n] = al.frame_start;
        assign bit_valid_vec[n]   = al.bit_valid;
        assign bit_vec[n]         = al.bit_out;

        stream_aligner u_align (
            .pclk    (pclk),
            .presetn (presetn),
            .al      (al)
        );
    end
endmodule : stream_input_frame_offset

/* tb/stream_offset_chk.sv */
/* port-level checker for the stream frame offset block.
   assumes only the top module's ports are visible; bound below. */
`timescale 1ns/1ps
module stream_offset_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        frame_pulse_in,
    input wire logic [15:0] rx_frame_start,
    input wire logic [15:0] rx_bit_valid,
    input wire logic [15:0] rx_bit
);
    logic [15:0] shadow [4];
    logic [9:0]  idx;
    logic        mapped;
    logic        offs;
    assign idx    = paddr[11:2];
    assign mapped = idx >= 10'h003 && idx <= 10'h008;
    assign offs   = idx >= 10'h003 && idx <= 10'h006;
    // expected offset register contents
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++)
                shadow[i] <= 16'h0000;
        end else if (psel && penable && pwrite && offs) begin
            shadow[idx[1:0] + 2'h1] <= pwdata[15:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_reset_clear: assert property ($rose(presetn) |-> prdata == 32'h0 && !pslverr
        && rx_bit_valid == 16'h0) else $error("outputs not clear after reset");
    a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr
        && prdata == 32'h0) else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_read_back: assert property (psel && penable && !pwrite && offs |->
        prdata == {16'h0000, shadow[idx[1:0] + 2'h1]}) else $error("offset readback wrong");
    a_start_pulse: assert property (|rx_frame_start |=>
        (rx_frame_start & $past(rx_frame_start)) == 16'h0) else $error("start not a pulse");
    a_start_valid: assert property ((rx_frame_start & ~rx_bit_valid) == 16'h0)
        else $error("start without bit");
    a_bit_holds: assert property (((rx_bit ^ $past(rx_bit)) & ~rx_bit_valid) == 16'h0)
        else $error("bit changed without valid");
    a_quiet_ref: assert property ($rose(frame_pulse_in) |=> (rx_frame_start == 16'h0) [*2])
        else $error("start too soon after frame pulse");
endmodule : stream_offset_chk

bind stream_input_frame_offset stream_offset_chk chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_pulse_in(frame_pulse_in),
    .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

/* tb/stream_source_model.sv */
/* upstream source: frame pulse, link clock of 8 pclk periods, 16 streams.
   assumes go is a one-cycle request in the pclk domain. */
`timescale 1ns/1ps
module stream_source_model #(
    parameter logic [15:0] pattern = 16'h3c5a
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    output logic             link_clk,
    output logic             frame_pulse,
    output logic      [15:0] streams
);
    logic       run;
    logic [6:0] t;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            t   <= 7'h00;
        end else if (go) begin
            run <= 1'b1;
            t   <= 7'h00;
        end else if (run) begin
            run <= t != 7'h3c;
            t   <= t + 7'h01;
        end
    end
    // clock still outside frames; first rise three cycles after the pulse
    assign link_clk    = run && t >= 7'h03 && ((t - 7'h03) & 7'h04) == 7'h00;
    assign frame_pulse = run && t < 7'h02;
    assign streams     = run ? pattern : ~pattern;
endmodule : stream_source_model

/* tb/tb_stream_input_frame_offset.sv */
/* testbench: offset registers over apb and per-stream frame alignment.
   assumes the source model stands on the stream side. */
`timescale 1ns/1ps
module tb_stream_input_frame_offset;
    localparam logic [15:0] pattern = 16'h3c5a;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        go      = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, link_clk, frame_pulse, er;
    logic [15:0] streams, rx_frame_start, rx_bit_valid, rx_bit;
    int          err_total = 0;
    int          tests_run = 0;

    always #50 pclk = ~pclk;
    stream_source_model #(.pattern(pattern)) src (.pclk(pclk), .presetn(presetn), .go(go),
        .link_clk(link_clk), .frame_pulse(frame_pulse), .streams(streams));
    stream_input_frame_offset dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk_in(link_clk),
        .frame_pulse_in(frame_pulse), .serial_stream_in(streams),
        .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

    task automatic test_done;
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask : apb

    task automatic t_regs;
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, 12'h00c + 12'(4 * r), 32'h0);
            chk("offset reset", 32'h0, rd);
        end
        for (int r = 0; r < 4; r++)
            apb(1'b1, 12'h00c + 12'(4 * r), 32'hbeefa5f0 ^ (32'(r) * 32'h1111));
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, 12'h00c + 12'(4 * r), 32'h0);
            chk("offset readback", 32'h0000a5f0 ^ (32'(r) * 32'h1111), rd);
        end
        apb(1'b1, 12'h000, 32'hffff);
        chk("unmapped write error", 32'h1, 32'(er));
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped read data", 32'h0, rd);
    endtask : t_regs

    task automatic t_align(input logic gci, input logic wr);
        logic [7:0]  first [16];
        logic [31:0] w;
        logic [31:0] s;
        if (wr) begin
            for (int r = 0; r < 4; r++) begin
                w = 32'h0;
                for (int j = 0; j < 4; j++)
                    w[4 * j +: 4] = 4'((4 * r + j) % 10);
                apb(1'b1, 12'h00c + 12'(4 * r), w);
            end
            apb(1'b1, 12'h01c, {31'h0, gci});
            apb(1'b0, 12'h01c, 32'h0);
            chk("mode readback", {31'h0, gci}, rd);
        end
        for (int n = 0; n < 16; n++)
            first[n] = 8'hff;
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(negedge pclk);
            for (int n = 0; n < 16; n++)
                if (rx_frame_start[n] === 1'b1 && first[n] == 8'hff) begin
                    first[n] = 8'(i);
                    chk("captured bit", 32'(pattern[n]), 32'(rx_bit[n]));
                end
        end
        // setting s: capture on link edge s, one later in gci mode
        for (int n = 0; n < 16; n++) begin
            s = wr ? 32'(n % 10 + gci) : 32'h0;
            chk("start cycle", 32'h4 + 32'h4 * s, 32'(first[n]));
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("status", 32'h0000ffff, rd);
    endtask : t_align

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_align(1'b0, 1'b1);
        t_align(1'b1, 1'b1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        t_align(1'b0, 1'b0);
        test_done();
    end
endmodule : tb_stream_input_frame_offset
